// ===== src/eprc_defs.svh
/*
  Constants for the enclave page restriction checker: leaf codes, field
  positions, return codes and the host-bus register map.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef EPRC_DEFS_SVH
`define EPRC_DEFS_SVH

// ---------------------------------------------------------------
// leaf selector values
// ---------------------------------------------------------------
`define EPRC_LEAF_RESTRICT     8'h0E
`define EPRC_LEAF_CHTYPE       8'h0F

// ---------------------------------------------------------------
// alignment masks (64-byte record, 4-kbyte page)
// ---------------------------------------------------------------
`define EPRC_REC_ALIGN_MASK    32'h0000003F
`define EPRC_PAGE_ALIGN_MASK   32'h00000FFF

// ---------------------------------------------------------------
// return codes in the result register
// ---------------------------------------------------------------
`define EPRC_RC_OK             32'h00000000
`define EPRC_RC_LOCKED         32'h00000001
`define EPRC_RC_CONFLICT       32'h00000002

// ---------------------------------------------------------------
// page types
// ---------------------------------------------------------------
`define EPRC_REGULAR_PAGE_TYPE            8'h02
`define EPRC_PT_TCS            8'h03
`define EPRC_PT_TRIM           8'h04

// ---------------------------------------------------------------
// page security map geometry
// ---------------------------------------------------------------
`define EPRC_MAP_DEPTH         16
`define EPRC_MAP_IDX_W         4
`define EPRC_POOL_BASE         32'h00100000
`define EPRC_POOL_TOP          32'h00110000

// ---------------------------------------------------------------
// register byte offsets (AXI4-Lite)
// ---------------------------------------------------------------
`define EPRC_REG_LEAF          8'h00
`define EPRC_REG_RECPTR        8'h04
`define EPRC_REG_PAGEPTR       8'h08
`define EPRC_REG_RECFLAGS      8'h0C
`define EPRC_REG_RECRSVD       8'h10
`define EPRC_REG_ENV           8'h14
`define EPRC_REG_GO            8'h18
`define EPRC_REG_RESULT        8'h1C
`define EPRC_REG_STATUS        8'h20
`define EPRC_REG_MAPIDX        8'h24
`define EPRC_REG_MAPDATA       8'h28

// ---------------------------------------------------------------
// bus responses
// ---------------------------------------------------------------
`define EPRC_RESP_OKAY         2'b00
`define EPRC_RESP_SLVERR       2'b10

`endif

// ===== src/eprc_pkg.sv
/*
  Types of the enclave page restriction checker.
  Assumes eprc_defs.svh is on the include path.
*/
`include "eprc_defs.svh"

package eprc_pkg;

  // one page security map entry
  typedef struct packed {
    logic       valid;
    logic       pending;
    logic       modified;
    logic       restriction_pending_bit;
    logic       blocked;
    logic [7:0] page_type;
    logic       perm_r;
    logic       perm_w;
    logic       perm_x;
  } eprc_entry_type;

  // flags of the security info record
  typedef struct packed {
    logic [7:0] page_type;
    logic       perm_r;
    logic       perm_w;
    logic       perm_x;
  } eprc_record_type;

  // outcome of one leaf
  typedef struct packed {
    logic        protection_fault;
    logic        page_fault_exception;
    logic        zero_flag;
    logic        arith_flags;
    logic [31:0] result_register;
  } eprc_result_type;

  // environment bits from the rest of the processor
  typedef struct packed {
    logic [1:0] cpl;
    logic       ext_set_enabled;
    logic       base_busy;
    logic       ext_busy;
    logic       control_locked;
    logic       control_init;
  } eprc_env_type;

  typedef enum logic [1:0] {
    EPRC_IDLE  = 2'b00,
    EPRC_CHECK = 2'b01,
    EPRC_DONE  = 2'b11
  } eprc_state_type;

endpackage

// ===== src/eprc_checker.sv
/*
  Combinational check chain for both page-modification leaves.
  Assumes the caller holds every input stable while it samples the outputs.
*/
`timescale 1ns/1ps
`include "eprc_defs.svh"

module eprc_checker (
  input  wire logic [7:0]               leaf_in,      // leaf selector
  input  wire logic [31:0]              rec_ptr_in,   // record pointer register
  input  wire logic [31:0]              page_ptr_in,  // page pointer register
  input  wire eprc_pkg::eprc_record_type rec_in,      // record flags
  input  wire logic                     rec_rsvd_in,  // any reserved field set
  input  wire eprc_pkg::eprc_env_type   env_in,       // environment
  input  wire eprc_pkg::eprc_entry_type entry_in,     // current map entry
  output logic                          write_out,    // commit new entry
  output eprc_pkg::eprc_entry_type      entry_out,    // new entry value
  output eprc_pkg::eprc_result_type     result_out    // flags and code
);
  import eprc_pkg::*;

  wire is_restrict = (leaf_in == `EPRC_LEAF_RESTRICT);
  wire is_chtype   = (leaf_in == `EPRC_LEAF_CHTYPE);
  wire leaf_ok     = (is_restrict | is_chtype) & env_in.ext_set_enabled
                     & (env_in.cpl == 2'b00);
  wire rec_misal   = |(rec_ptr_in & `EPRC_REC_ALIGN_MASK);
  wire page_misal  = |(page_ptr_in & `EPRC_PAGE_ALIGN_MASK);
  wire out_pool    = (page_ptr_in < `EPRC_POOL_BASE)
                     | (page_ptr_in >= `EPRC_POOL_TOP);
  wire bad_rwx     = is_restrict & ~rec_in.perm_r & rec_in.perm_w;
  wire bad_type    = is_chtype & (rec_in.page_type != `EPRC_PT_TCS)
                     & (rec_in.page_type != `EPRC_PT_TRIM);
  wire bad_rec     = rec_rsvd_in | bad_rwx | bad_type;
  // restrict faults on any base-set user, type change only reports it
  wire base_clash  = env_in.base_busy;
  wire ext_clash   = env_in.ext_busy | env_in.control_locked;
  wire not_valid   = ~entry_in.valid;
  wire locked      = entry_in.pending | entry_in.modified;
  wire reg_type    = (entry_in.page_type == `EPRC_REGULAR_PAGE_TYPE);
  wire tcs_trim    = (entry_in.page_type == `EPRC_PT_TCS)
                     & (rec_in.page_type == `EPRC_PT_TRIM);
  wire wrong_type  = is_restrict ? ~reg_type : ~(reg_type | tcs_trim);
  wire not_init    = ~env_in.control_init;

  // first failing check wins; entry untouched unless every check passes
  always_comb begin
    result_out = '0;
    entry_out  = entry_in;
    write_out  = 1'b0;
    if (!leaf_ok || rec_misal || page_misal) begin
      result_out.protection_fault = 1'b1;
    end else if (out_pool) begin
      result_out.page_fault_exception = 1'b1;
    end else if (bad_rec || (base_clash && is_restrict)) begin
      result_out.protection_fault = 1'b1;
    end else if (base_clash) begin
      result_out.zero_flag       = 1'b1;
      result_out.result_register = `EPRC_RC_CONFLICT;
    end else if (not_valid) begin
      result_out.page_fault_exception = 1'b1;
    end else if (ext_clash) begin
      result_out.zero_flag       = 1'b1;
      result_out.result_register = `EPRC_RC_CONFLICT;
    end else if (is_restrict && locked) begin
      result_out.zero_flag       = 1'b1;
      result_out.result_register = `EPRC_RC_LOCKED;
    end else if (wrong_type) begin
      result_out.page_fault_exception = 1'b1;
    end else if (locked) begin
      result_out.zero_flag       = 1'b1;
      result_out.result_register = `EPRC_RC_LOCKED;
    end else if (not_init) begin
      result_out.protection_fault = 1'b1;
    end else if (is_restrict) begin
      write_out = 1'b1;
      entry_out.restriction_pending_bit = 1'b1;
      entry_out.perm_r = entry_in.perm_r & rec_in.perm_r;
      entry_out.perm_w = entry_in.perm_w & rec_in.perm_w;
      entry_out.perm_x = entry_in.perm_x & rec_in.perm_x;
      result_out.result_register = `EPRC_RC_OK;
    end else begin
      write_out = 1'b1;
      entry_out.restriction_pending_bit = 1'b0;
      entry_out.modified  = 1'b1;
      {entry_out.perm_r, entry_out.perm_w, entry_out.perm_x} = 3'b000;
      entry_out.page_type = rec_in.page_type;
    end
  end

endmodule

// ===== src/eprc_axil_regs.sv
/*
  AXI4-Lite slave decode helpers: address decode and read mux.
  Assumes one outstanding write and one outstanding read.
*/
`timescale 1ns/1ps
`include "eprc_defs.svh"

module eprc_axil_regs (
  input  wire logic [7:0]  raddr_in,   // read byte address
  input  wire logic [31:0] leaf_in,    // leaf register
  input  wire logic [31:0] recptr_in,  // record pointer
  input  wire logic [31:0] pageptr_in, // page pointer
  input  wire logic [31:0] recfl_in,   // record flags
  input  wire logic [31:0] recrsvd_in, // record reserved word
  input  wire logic [31:0] env_in,     // environment word
  input  wire logic [31:0] result_in,  // result register
  input  wire logic [31:0] status_in,  // status word
  input  wire logic [31:0] mapidx_in,  // map index
  input  wire logic [31:0] mapdata_in, // selected map entry
  output logic [31:0]      rdata_out,  // read data
  output logic             rhit_out    // address mapped
);

  always_comb begin
    rhit_out  = 1'b1;
    rdata_out = 32'h00000000;
    if (raddr_in == `EPRC_REG_LEAF) rdata_out = leaf_in;
    else if (raddr_in == `EPRC_REG_RECPTR) rdata_out = recptr_in;
    else if (raddr_in == `EPRC_REG_PAGEPTR) rdata_out = pageptr_in;
    else if (raddr_in == `EPRC_REG_RECFLAGS) rdata_out = recfl_in;
    else if (raddr_in == `EPRC_REG_RECRSVD) rdata_out = recrsvd_in;
    else if (raddr_in == `EPRC_REG_ENV) rdata_out = env_in;
    else if (raddr_in == `EPRC_REG_GO) rdata_out = 32'h00000000;
    else if (raddr_in == `EPRC_REG_RESULT) rdata_out = result_in;
    else if (raddr_in == `EPRC_REG_STATUS) rdata_out = status_in;
    else if (raddr_in == `EPRC_REG_MAPIDX) rdata_out = mapidx_in;
    else if (raddr_in == `EPRC_REG_MAPDATA) rdata_out = mapdata_in;
    else rhit_out = 1'b0;
  end

endmodule

// ===== src/eprc_top.sv
/*
  Enclave page restriction checker: holds the page security map and runs
  the restrict-permissions and change-type leaves issued over AXI4-Lite.
  Assumes a single 250 MHz clock and asynchronous active-low reset.
*/
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "eprc_defs.svh"

// Functional notes
// - fault on record pointer not 64-byte aligned
// - fault on page pointer not 4k aligned
// - page fault when page outside pool
// - fault on reserved bits or write-without-read
// - restrict faults when base-set user active
// - page fault when map entry invalid
// - other extended user: zero flag, conflict
// - pending or modified: zero flag, locked code
// - restrict page-faults on non-regular page type
// - fault when owning control struct uninitialised
// - restrict success sets pending bit, ANDs permissions
// - clear arithmetic flags; success clears zero
// - leaves only at privilege level zero
// - selector 0FH picks type change leaf
// - type change blocks page until accept
// - type change reports conflict for writers
// - restrict exclusive against modifying leaves
// - record outside-readable, page inside-accessible
// - selector 0EH restricts; mask never widens
module eprc_top (
  input  wire logic        mclk_in,        // 250 MHz clock
  input  wire logic        arst_n_in,      // async reset, active low
  input  wire logic [7:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // write strobes
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [7:0]  s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  output logic             done_out        // leaf finished pulse
);
  import eprc_pkg::*;

  // --------------------
  // state
  // --------------------
  logic [7:0]        leaf;
  logic [31:0]       rec_ptr;
  logic [31:0]       page_ptr;
  eprc_record_type   rec;
  logic [31:0]       rec_rsvd;
  eprc_env_type      env;
  eprc_result_type   result;
  logic [3:0]        map_idx;
  eprc_state_type    state;
  eprc_entry_type    map_mem [`EPRC_MAP_DEPTH];
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  // --------------------
  // helpers
  // --------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return m;
  endfunction

  function automatic logic [3:0] page_index(input logic [31:0] addr);
    return addr[15:12];
  endfunction

  // --------------------
  // write channel decode
  // --------------------
  wire wr_fire  = aw_held && w_held && !s_axi_bvalid;
  wire busy     = (state != EPRC_IDLE);
  wire hit_leaf = (aw_addr == `EPRC_REG_LEAF);
  wire hit_rp   = (aw_addr == `EPRC_REG_RECPTR);
  wire hit_pp   = (aw_addr == `EPRC_REG_PAGEPTR);
  wire hit_rf   = (aw_addr == `EPRC_REG_RECFLAGS);
  wire hit_rr   = (aw_addr == `EPRC_REG_RECRSVD);
  wire hit_env  = (aw_addr == `EPRC_REG_ENV);
  wire hit_go   = (aw_addr == `EPRC_REG_GO);
  wire hit_idx  = (aw_addr == `EPRC_REG_MAPIDX);
  wire hit_map  = (aw_addr == `EPRC_REG_MAPDATA);
  wire wr_hit   = hit_leaf | hit_rp | hit_pp | hit_rf | hit_rr | hit_env
                  | hit_go | hit_idx | hit_map
                  | (aw_addr == `EPRC_REG_RESULT) | (aw_addr == `EPRC_REG_STATUS);
  // operand writes while a leaf runs would corrupt the check, so refuse
  wire wr_ok    = wr_hit && !busy;
  wire start    = wr_fire && wr_ok && hit_go && w_data[0];

  wire [31:0] next_leaf  = merge({24'h000000, leaf}, w_data, w_strb);
  wire [31:0] next_rf    = merge({21'h000000, rec}, w_data, w_strb);
  wire [31:0] next_env   = merge({25'h0000000, env}, w_data, w_strb);
  wire [31:0] next_idx   = merge({28'h0000000, map_idx}, w_data, w_strb);
  wire [31:0] map_word   = {16'h0000, map_mem[map_idx]};
  wire [31:0] next_map   = merge(map_word, w_data, w_strb);

  // --------------------
  // checker
  // --------------------
  wire [3:0]       pidx = page_index(page_ptr);
  logic            chk_write;
  eprc_entry_type  chk_entry;
  eprc_result_type chk_result;

  eprc_checker u_checker (
    .leaf_in     (leaf),
    .rec_ptr_in  (rec_ptr),
    .page_ptr_in (page_ptr),
    .rec_in      (rec),
    .rec_rsvd_in (|rec_rsvd),
    .env_in      (env),
    .entry_in    (map_mem[pidx]),
    .write_out   (chk_write),
    .entry_out   (chk_entry),
    .result_out  (chk_result)
  );

  // --------------------
  // read decode
  // --------------------
  logic [31:0] rd_word;
  logic        rd_hit;
  wire  [31:0] status_word = {27'h0000000, busy, result.protection_fault,
                              result.page_fault_exception, result.zero_flag,
                              result.arith_flags};

  eprc_axil_regs u_regs (
    .raddr_in   (s_axi_araddr),
    .leaf_in    ({24'h000000, leaf}),
    .recptr_in  (rec_ptr),
    .pageptr_in (page_ptr),
    .recfl_in   ({21'h000000, rec}),
    .recrsvd_in (rec_rsvd),
    .env_in     ({25'h0000000, env}),
    .result_in  (result.result_register),
    .status_in  (status_word),
    .mapidx_in  ({28'h0000000, map_idx}),
    .mapdata_in (map_word),
    .rdata_out  (rd_word),
    .rhit_out   (rd_hit)
  );

  // --------------------
  // bus write side
  // --------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EPRC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `EPRC_RESP_OKAY : `EPRC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // --------------------
  // operand registers
  // --------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      leaf     <= 8'h00;
      rec_ptr  <= 32'h00000000;
      page_ptr <= 32'h00000000;
      rec      <= '0;
      rec_rsvd <= 32'h00000000;
      env      <= '0;
      map_idx  <= 4'h0;
    end else if (wr_fire && wr_ok) begin
      if (hit_leaf) leaf <= next_leaf[7:0];
      if (hit_rp) rec_ptr <= merge(rec_ptr, w_data, w_strb);
      if (hit_pp) page_ptr <= merge(page_ptr, w_data, w_strb);
      if (hit_rf) rec <= next_rf[10:0];
      if (hit_rr) rec_rsvd <= merge(rec_rsvd, w_data, w_strb);
      if (hit_env) env <= next_env[6:0];
      if (hit_idx) map_idx <= next_idx[3:0];
    end
  end

  // --------------------
  // leaf sequencer and map
  // --------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state    <= EPRC_IDLE;
      result   <= '0;
      done_out <= 1'b0;
      for (int i = 0; i < `EPRC_MAP_DEPTH; i++) map_mem[i] <= '0;
    end else begin
      done_out <= 1'b0;
      case (state)
        EPRC_IDLE: begin
          if (start) state <= EPRC_CHECK;
          else if (wr_fire && wr_ok && hit_map) map_mem[map_idx] <= next_map[15:0];
        end
        EPRC_CHECK: begin
          result <= chk_result;
          if (chk_write) map_mem[pidx] <= chk_entry;
          state <= EPRC_DONE;
        end
        EPRC_DONE: begin
          done_out <= 1'b1;
          state    <= EPRC_IDLE;
        end
        default: state <= EPRC_IDLE;
      endcase
    end
  end

  // --------------------
  // bus read side
  // --------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `EPRC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `EPRC_RESP_OKAY : `EPRC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

endmodule

// ===== verification/eprc_monitor.sv
/* Bus and completion assertions for eprc_top.
   Assumes binding onto eprc_top ports by name. */
`timescale 1ns/1ps
`include "eprc_defs.svh"
module eprc_monitor (
  input wire logic        mclk_in,       // clock
  input wire logic        arst_n_in,     // reset, active low
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic [1:0]  s_axi_rresp,   // read response
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic        done_out       // leaf done
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while pending");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pends");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while answer pends");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `EPRC_RESP_SLVERR
    |-> s_axi_rdata == 32'h00000000) else $error("error read returned data");
  a_done_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_done_after_go: assert property (done_out |-> $past(s_axi_bvalid, 2))
    else $error("done without start two cycles before");
endmodule

// ===== verification/eprc_sw_model.sv
/* Software side: register accesses to eprc_top over AXI4-Lite.
   Assumes the bench calls wr and rd one at a time. */
`timescale 1ns/1ps
module eprc_sw_model (
  input  wire logic        mclk_in,       // clock
  output logic [7:0]       s_axi_awaddr,  // aw addr
  output logic             s_axi_awvalid, // aw valid
  input  wire logic        s_axi_awready, // aw ready
  output logic [31:0]      s_axi_wdata,   // w data
  output logic [3:0]       s_axi_wstrb,   // w strobes
  output logic             s_axi_wvalid,  // w valid
  input  wire logic        s_axi_wready,  // w ready
  input  wire logic [1:0]  s_axi_bresp,   // b resp
  input  wire logic        s_axi_bvalid,  // b valid
  output logic             s_axi_bready,  // b ready
  output logic [7:0]       s_axi_araddr,  // ar addr
  output logic             s_axi_arvalid, // ar valid
  input  wire logic        s_axi_arready, // ar ready
  input  wire logic [31:0] s_axi_rdata,   // r data
  input  wire logic [1:0]  s_axi_rresp,   // r resp
  input  wire logic        s_axi_rvalid,  // r valid
  output logic             s_axi_rready   // r ready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    // released lines must not keep showing the last value
    s_axi_awaddr <= ~a;
    s_axi_wdata  <= ~d;
    while (!s_axi_bvalid) @(posedge mclk_in);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge mclk_in); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    while (!s_axi_rvalid) @(posedge mclk_in);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ===== verification/tb_top.sv
/* Self-checking bench for eprc_top: leaves issued through eprc_sw_model.
   Assumes the package, design, model and monitor are compiled first. */
`timescale 1ns/1ps
`include "eprc_defs.svh"
module tb_top;
  import eprc_pkg::*;
  localparam logic [7:0]  RS = `EPRC_LEAF_RESTRICT;
  localparam logic [31:0] P  = `EPRC_POOL_BASE;
  localparam logic [31:0] E  = 32'h00000011;
  localparam logic [4:0]  GP = 5'h08;
  localparam logic [4:0]  PF = 5'h04;
  localparam logic [4:0]  ZF = 5'h02;
  logic        mclk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rtype;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, rsvd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        done_out;
  int          miscompares = 0;
  int          checked = 0;
  always #2 mclk_in = ~mclk_in;
  eprc_top DUT (.*);
  eprc_sw_model sw (.*);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] ent(input logic [3:0] vpmr, input logic [7:0] t,
                                      input logic [2:0] rwx);
    return {16'h0000, vpmr, 1'b0, t, rwx};
  endfunction
  task automatic map(input logic [3:0] i, input logic [31:0] e, input bit wrt);
    sw.wr(`EPRC_REG_MAPIDX, 32'(i), rs);
    if (wrt) sw.wr(`EPRC_REG_MAPDATA, e, rs);
    else sw.rd(`EPRC_REG_MAPDATA, rv, rs);
    if (!wrt) check("map entry", rv, e);
  endtask
  task automatic leaf(input logic [7:0] sel, input logic [31:0] rec, input logic [31:0] pg,
                      input logic [2:0] rwx, input logic [31:0] env, input logic [4:0] st,
                      input logic [31:0] rc);
    sw.wr(`EPRC_REG_LEAF, 32'(sel), rs);
    sw.wr(`EPRC_REG_RECPTR, rec, rs);
    sw.wr(`EPRC_REG_PAGEPTR, pg, rs);
    sw.wr(`EPRC_REG_RECFLAGS, {21'h000000, rtype, rwx}, rs);
    sw.wr(`EPRC_REG_RECRSVD, rsvd, rs);
    sw.wr(`EPRC_REG_ENV, env, rs);
    sw.wr(`EPRC_REG_GO, 32'h00000001, rs);
    check("go resp", 32'(rs), 32'(`EPRC_RESP_OKAY));
    repeat (20) if (!done_out) @(posedge mclk_in);
    check("done", 32'(done_out), 32'h00000001);
    sw.rd(`EPRC_REG_STATUS, rv, rs);
    check("status", rv, 32'(st));
    sw.rd(`EPRC_REG_RESULT, rv, rs);
    if (st[3:2] == 2'b00) check("result", rv, rc);
  endtask
  initial begin
    rtype = `EPRC_REGULAR_PAGE_TYPE;
    rsvd = 32'h00000000;
    repeat (10) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    map(4'h2, 32'h00000000, 1'b0);
    sw.rd(8'h3C, rv, rs);
    check("unmapped resp", 32'(rs), 32'(`EPRC_RESP_SLVERR));
    map(4'h1, ent(4'b1000, `EPRC_REGULAR_PAGE_TYPE, 3'b111), 1'b1);
    map(4'h3, ent(4'b1010, `EPRC_REGULAR_PAGE_TYPE, 3'b111), 1'b1);
    map(4'h4, ent(4'b1000, `EPRC_PT_TCS, 3'b111), 1'b1);
    leaf(RS, 32'h41, 32'h00200000, 3'b101, E, GP, 0);
    leaf(RS, 32'h40, P + 32'h1800, 3'b101, E, GP, 0);
    leaf(RS, 32'h40, 32'h00200000, 3'b101, E, PF, 0);
    leaf(RS, 32'h40, P + 32'h1000, 3'b010, E, GP, 0);
    rsvd = 32'h00000001;
    leaf(RS, 32'h40, P + 32'h1000, 3'b101, E, GP, 0);
    rsvd = 32'h00000000;
    leaf(RS, 32'h40, P + 32'h1000, 3'b101, E | 32'h08, GP, 0);
    leaf(RS, 32'h40, P + 32'h1000, 3'b101, E | 32'h04, ZF, `EPRC_RC_CONFLICT);
    leaf(RS, 32'h40, P + 32'h1000, 3'b101, E | 32'h20, GP, 0);
    leaf(RS, 32'h40, P + 32'h1000, 3'b101, 32'h10, GP, 0);
    leaf(RS, 32'h40, P + 32'h2000, 3'b101, E, PF, 0);
    leaf(RS, 32'h40, P + 32'h3000, 3'b101, E, ZF, `EPRC_RC_LOCKED);
    leaf(RS, 32'h40, P + 32'h4000, 3'b101, E, PF, 0);
    map(4'h3, ent(4'b1010, `EPRC_REGULAR_PAGE_TYPE, 3'b111), 1'b0);
    map(4'h1, ent(4'b1000, `EPRC_REGULAR_PAGE_TYPE, 3'b111), 1'b0);
    leaf(RS, 32'h40, P + 32'h1000, 3'b101, E, 5'h00, `EPRC_RC_OK);
    map(4'h1, ent(4'b1001, `EPRC_REGULAR_PAGE_TYPE, 3'b101), 1'b0);
    leaf(RS, 32'h40, P + 32'h1000, 3'b111, E, 5'h00, `EPRC_RC_OK);
    map(4'h1, ent(4'b1001, `EPRC_REGULAR_PAGE_TYPE, 3'b101), 1'b0);
    rtype = `EPRC_PT_TRIM;
    leaf(`EPRC_LEAF_CHTYPE, 32'h40, P + 32'h1000, 3'b000, E | 32'h08, ZF,
         `EPRC_RC_CONFLICT);
    leaf(`EPRC_LEAF_CHTYPE, 32'h40, P + 32'h4000, 3'b000, E, 5'h00, `EPRC_RC_OK);
    map(4'h4, ent(4'b1010, `EPRC_PT_TRIM, 3'b000), 1'b0);
    conclude();
  end
  // whole run is under 800 cycles; this allows more than twelve times that
  initial begin
    #40000;
    miscompares++;
    conclude();
  end
endmodule
bind eprc_top eprc_monitor mon (.*);
